// File: hdl/tlbmo_defines.vh
`ifndef TLBMO_DEFINES_VH
`define TLBMO_DEFINES_VH
// Instruction fields, big-endian bit numbering mapped to [31:0]
`define TLBMO_PRIMARY_OP 6'h1F
`define TLBMO_XOP_INVAL 10'h172
`define TLBMO_XOP_READ 10'h3B2
`define TLBMO_XOP_SEARCH 10'h392
`define TLBMO_OPC_HI 31
`define TLBMO_OPC_LO 26
`define TLBMO_RD_HI 25
`define TLBMO_RD_LO 21
`define TLBMO_BASE_FLD_HI 20
`define TLBMO_BASE_FLD_LO 16
`define TLBMO_SEL_FLD_HI 15
`define TLBMO_SEL_FLD_LO 11
`define TLBMO_XO_HI 10
`define TLBMO_XO_LO 1
`define TLBMO_RECORD_BIT 0
// Entry geometry
`define TLBMO_ENTRIES 64
`define TLBMO_IDX_W 6
`define TLBMO_TAG_VALID 6
`define TLBMO_TAG_EPN_HI 31
`define TLBMO_TAG_EPN_LO 10
`define TLBMO_TRANS_ID_W 8
`define TLBMO_SEL_TAG 5'h00
`define TLBMO_SEL_DATA 5'h01
// Condition field bits: less, greater, equal, summary overflow
`define TLBMO_COND_LESS 3
`define TLBMO_COND_GREATER 2
`define TLBMO_COND_EQUAL 1
`define TLBMO_COND_SUMMARY 0
`endif

// File: hdl/tlbmo_entry_match.v
`timescale 1ns/100ps
`include "tlbmo_defines.vh"
// Compares one entry against an effective address and translation id
module tlbmo_entry_match (
  input wire [31:0] tagWord,
  input wire [7:0] entryId,
  input wire [31:0] effAddr,
  input wire [7:0] processId,
  output wire hit
);
  // Page number compare; zero id matches any process
  assign hit = tagWord[`TLBMO_TAG_VALID]
    && (tagWord[`TLBMO_TAG_EPN_HI:`TLBMO_TAG_EPN_LO]
        == effAddr[`TLBMO_TAG_EPN_HI:`TLBMO_TAG_EPN_LO])
    && ((entryId == processId) || (entryId == 8'h00));
endmodule

// File: hdl/tlbmo_unit.v
`timescale 1ns/100ps
`include "tlbmo_defines.vh"
// Operation
// - Invalidate-all clears the valid bit in the tag word of every entry.
// - Invalidate-all leaves every other field of each entry untouched.
// - Invalidate-all acts whether translation is enabled or not.
// - Any of the three operations in user mode raises a program exception instead.
// - Nonzero reserved bits give an undefined result, never an exception.
// - Read-entry takes the entry index from base operand bits 26:31.
// - Read-entry with word select zero returns the tag word and copies its id to the process id.
// - Read-entry with word select one returns the data word and keeps the process id.
// - Read-entry with word select above one is undefined, never an exception.
// - Read-entry acts whether translation is enabled or not.
// - Search address is index operand plus base operand, base zero when its field is zero.
// - Search finds a valid entry matching address and process id and returns its index.
// - Search acts whether translation is enabled or not.
// - With the record bit set, search clears less and greater, copies overflow, sets equal on hit.
module tlbmo_unit (
  input wire clk,
  input wire rst,
  input wire clkEn,
  input wire issueValid,
  input wire [31:0] instrWord,
  input wire [31:0] baseOperand,
  input wire [31:0] indexOperand,
  input wire userMode,
  input wire summaryOverflow,
  input wire [7:0] processIdIn,
  input wire writeEn,
  input wire writeWordSel,
  input wire [5:0] writeIndex,
  input wire [31:0] writeWord,
  input wire [7:0] writeTransId,
  output reg doneValid,
  output reg [31:0] destValue,
  output reg destWrite,
  output reg [4:0] destReg,
  output reg processIdWrite,
  output reg [7:0] processIdOut,
  output reg conditionWrite,
  output reg [3:0] conditionField,
  output reg programException
);
  // Operation codes
  localparam OP_NONE = 2'b00;
  localparam OP_INVAL = 2'b01;
  localparam OP_READ = 2'b10;
  localparam OP_SEARCH = 2'b11;

  // Entry storage
  // sixty-four entries
  reg [31:0] tagMem [0:`TLBMO_ENTRIES-1];
  reg [31:0] dataMem [0:`TLBMO_ENTRIES-1];
  reg [7:0] transIdMem [0:`TLBMO_ENTRIES-1];
  reg [`TLBMO_ENTRIES-1:0] validBits;

  // Decode of the extended opcode; reserved fields are not checked
  function [1:0] decodeOp;
    input [31:0] iw;
    begin
      decodeOp = OP_NONE;
      if (iw[`TLBMO_OPC_HI:`TLBMO_OPC_LO] == `TLBMO_PRIMARY_OP) begin
        case (iw[`TLBMO_XO_HI:`TLBMO_XO_LO])
          `TLBMO_XOP_INVAL: decodeOp = OP_INVAL;
          `TLBMO_XOP_READ: decodeOp = OP_READ;
          `TLBMO_XOP_SEARCH: decodeOp = OP_SEARCH;
          default: decodeOp = OP_NONE;
        endcase
      end
    end
  endfunction

  // Tag word with the separately kept valid bit put back in place
  function [31:0] foldValid;
    input [31:0] tag;
    input v;
    begin
      foldValid = tag;
      foldValid[`TLBMO_TAG_VALID] = v;
    end
  endfunction

  // Instruction fields and operands
  wire [1:0] opKind = decodeOp(instrWord);
  wire [4:0] baseField = instrWord[`TLBMO_BASE_FLD_HI:`TLBMO_BASE_FLD_LO];
  wire [5:0] readIndex = baseOperand[`TLBMO_IDX_W-1:0];
  // Word select shares the index register field
  wire [4:0] wordSel = instrWord[`TLBMO_SEL_FLD_HI:`TLBMO_SEL_FLD_LO];
  wire [31:0] effAddr = (baseField == 5'h00 ? 32'h0 : baseOperand) + indexOperand;

  // Accepted operation and the privileged invalidate
  wire issueTaken = issueValid && (opKind != OP_NONE);
  wire invalidateAll = issueTaken && !userMode && (opKind == OP_INVAL);

  // parallel compare of all entries
  // One comparator per entry; area traded for a one-cycle search
  wire [`TLBMO_ENTRIES-1:0] hitVec;
  genvar g;
  generate
    for (g = 0; g < `TLBMO_ENTRIES; g = g + 1) begin : gMatch
      tlbmo_entry_match uMatch (
        .tagWord(foldValid(tagMem[g], validBits[g])),
        .entryId(transIdMem[g]),
        .effAddr(effAddr),
        .processId(processIdIn),
        .hit(hitVec[g])
      );
    end
  endgenerate

  // Lowest hit wins when entries overlap
  reg [5:0] hitIndex;
  integer k;
  always @* begin
    hitIndex = 6'h00;
    for (k = `TLBMO_ENTRIES - 1; k >= 0; k = k - 1) begin
      if (hitVec[k]) begin
        hitIndex = k[5:0];
      end
    end
  end
  wire anyHit = |hitVec;

  // Tag word as read, with the live valid bit folded in
  wire [31:0] readTag = foldValid(tagMem[readIndex], validBits[readIndex]);

  // Storage loads; no reset so the arrays stay plain RAM
  always @(posedge clk) begin
    if (clkEn && writeEn) begin
      if (writeWordSel) begin
        dataMem[writeIndex] <= writeWord;
      end else begin
        // Tag load also carries the owning translation id
        tagMem[writeIndex] <= writeWord;
        transIdMem[writeIndex] <= writeTransId;
      end
    end
  end

  // Valid bits kept apart so invalidate-all is one cycle
  // Reset clears only these; stale array words can never look valid
  always @(posedge clk) begin
    if (rst) begin
      validBits <= {`TLBMO_ENTRIES{1'b0}};
    end else if (clkEn) begin
      // Invalidate beats a same-cycle preload so no stale entry survives
      // clear valid only
      if (invalidateAll) begin
        validBits <= {`TLBMO_ENTRIES{1'b0}};
      end else if (writeEn && !writeWordSel) begin
        validBits[writeIndex] <= writeWord[`TLBMO_TAG_VALID];
      end
    end
  end

  // Result registers
  always @(posedge clk) begin
    if (rst) begin
      doneValid <= 1'b0;
      destValue <= 32'h0;
      destWrite <= 1'b0;
      destReg <= 5'h00;
      processIdWrite <= 1'b0;
      processIdOut <= 8'h00;
      conditionWrite <= 1'b0;
      conditionField <= 4'h0;
      programException <= 1'b0;
    end else if (clkEn) begin
      // Pulses last one enabled cycle; values hold for the pipeline
      doneValid <= 1'b0;
      destWrite <= 1'b0;
      processIdWrite <= 1'b0;
      conditionWrite <= 1'b0;
      programException <= 1'b0;
      if (issueTaken) begin
        doneValid <= 1'b1;
        destReg <= instrWord[`TLBMO_RD_HI:`TLBMO_RD_LO];
        // privileged only; reserved bits never trap
        if (userMode) begin
          // Trapped operation changes nothing but the exception and done pulses and destReg
          programException <= 1'b1;
        end else begin
          case (opKind)
            OP_READ: begin
              destWrite <= 1'b1;
              if (wordSel == `TLBMO_SEL_TAG) begin
                destValue <= readTag;
                processIdWrite <= 1'b1;
                processIdOut <= transIdMem[readIndex];
              end else begin
                // data word for any nonzero select
                destValue <= dataMem[readIndex];
              end
            end
            OP_SEARCH: begin
              // search always; index on hit, zero otherwise
              // A miss returns zero, since the index is undefined then
              destWrite <= 1'b1;
              destValue <= {26'h0, hitIndex};
              // record form updates the condition field
              if (instrWord[`TLBMO_RECORD_BIT]) begin
                conditionWrite <= 1'b1;
                conditionField[`TLBMO_COND_LESS] <= 1'b0;
                conditionField[`TLBMO_COND_GREATER] <= 1'b0;
                conditionField[`TLBMO_COND_EQUAL] <= anyHit;
                conditionField[`TLBMO_COND_SUMMARY] <= summaryOverflow;
              end
            end
            default: begin
              destWrite <= 1'b0;
            end
          endcase
        end
      end
    end
  end
endmodule

// File: verification/tlbmo_checker.sv
`timescale 1ns/100ps
// Port-level timing checks on the management unit
module tlbmo_checker (
  input wire clk,
  input wire rst,
  input wire clkEn,
  input wire issueValid,
  input wire [31:0] instrWord,
  input wire userMode,
  input wire summaryOverflow,
  input wire doneValid,
  input wire [31:0] destValue,
  input wire destWrite,
  input wire [4:0] destReg,
  input wire processIdWrite,
  input wire conditionWrite,
  input wire [3:0] conditionField,
  input wire programException
);
  // Decode; unknown opcodes are simply ignored
  wire [9:0] xo = instrWord[10:1];
  wire ok = issueValid && clkEn && instrWord[31:26] == 6'h1F
    && (xo == 10'h172 || xo == 10'h3B2 || xo == 10'h392);
  wire go = ok && !userMode;
  wire inv = go && xo == 10'h172;
  wire rd = go && xo == 10'h3B2;
  wire sx = go && xo == 10'h392;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_TRAP: assert property (ok && userMode |=> programException && !destWrite)
    else $error("user issue not trapped");
  AST_DONE: assert property (go |=> doneValid && !programException)
    else $error("privileged issue not completed");
  AST_RD_TAG: assert property (rd && instrWord[15:11] == 5'h00 |=> processIdWrite
    && destReg == $past(instrWord[25:21])) else $error("tag read wrong");
  AST_RD_DATA: assert property (rd && instrWord[15:11] != 5'h00 |=>
    !processIdWrite && destWrite) else $error("data read wrong");
  AST_CR_REC: assert property (sx && instrWord[0] |=> conditionWrite
    && conditionField[3:2] == 2'h0 && conditionField[0] == $past(summaryOverflow))
    else $error("condition field wrong");
  AST_CR_NONE: assert property (sx && !instrWord[0] |=> !conditionWrite && destWrite)
    else $error("unrecorded search wrong");
  AST_HIT: assert property (conditionWrite && conditionField[1] |-> destValue[31:6] == 26'h0)
    else $error("hit index out of range");
  AST_INVAL: assert property (inv |=> doneValid && !destWrite && !conditionWrite)
    else $error("invalidate wrote outputs");
endmodule
bind tlbmo_unit tlbmo_checker chk (.clk, .rst, .clkEn, .issueValid, .instrWord, .userMode,
  .summaryOverflow, .doneValid, .destValue, .destWrite, .destReg, .processIdWrite,
  .conditionWrite, .conditionField, .programException);

// File: verification/tlbmo_issuer.sv
`timescale 1ns/100ps
// Pipeline side: one instruction per call
module tlbmo_issuer (
  input wire clk,
  output reg issueValid = 1'b0,
  output reg [31:0] instrWord = 32'h0,
  output reg [31:0] baseOperand = 32'h0,
  output reg [31:0] indexOperand = 32'h0
);
  task op(input [31:0] iw, input [31:0] b, input [31:0] x);
    begin
      @(posedge clk);
      #1;
      issueValid = 1'b1;
      instrWord = iw;
      baseOperand = b;
      indexOperand = x;
      @(posedge clk);
      #1;
      // Released bus shows junk, not stale values
      issueValid = 1'b0;
      instrWord = ~iw;
      baseOperand = ~b;
      indexOperand = ~x;
    end
  endtask
endmodule

// File: verification/tlbmo_unit_test.sv
`timescale 1ns/100ps
module tlbmo_unit_test;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg clkEn = 1'b1;
  reg userMode = 1'b0;
  reg summaryOverflow = 1'b1;
  // Foreign id until the searches, so the read-back copy stands out
  reg [7:0] processIdIn = 8'hA5;
  reg writeEn = 1'b0;
  reg writeWordSel = 1'b0;
  reg [5:0] writeIndex = 6'h3F;
  reg [31:0] writeWord = 32'h0;
  reg [7:0] writeTransId = 8'h5A;
  wire issueValid, doneValid, destWrite, processIdWrite, conditionWrite, programException;
  wire [31:0] instrWord, baseOperand, indexOperand, destValue;
  wire [4:0] destReg;
  wire [7:0] processIdOut;
  wire [3:0] conditionField;
  integer n_mismatch = 0;
  integer checks_done = 0;
  integer cyc = 0;
  tlbmo_unit dut (.clk, .rst, .clkEn, .issueValid, .instrWord, .baseOperand, .indexOperand,
    .userMode, .summaryOverflow, .processIdIn, .writeEn, .writeWordSel, .writeIndex,
    .writeWord, .writeTransId, .doneValid, .destValue, .destWrite, .destReg, .processIdWrite,
    .processIdOut, .conditionWrite, .conditionField, .programException);
  tlbmo_issuer pipe (.clk, .issueValid, .instrWord, .baseOperand, .indexOperand);
  initial forever #20 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  function [31:0] iw(input [9:0] x, input [4:0] a, input [4:0] b, input c);
    iw = {6'h1F, 5'h03, a, b, x, c};
  endfunction
  task ck(input [31:0] seen, input [31:0] want);
    begin
      checks_done = checks_done + 1;
      if (seen !== want) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: %h, expected %h", $time, seen, want);
      end
    end
  endtask
  // Preload path into entry 63
  task wr(input s, input [31:0] w);
    begin
      @(posedge clk);
      #1;
      writeEn = 1'b1;
      writeWordSel = s;
      writeWord = w;
      @(posedge clk);
      #1;
      writeEn = 1'b0;
    end
  endtask
  // Top index, upper base bits must be ignored
  task t_read;
    begin
      wr(1'b0, 32'h1234_5440);
      wr(1'b1, 32'hCAFE_0123);
      pipe.op(iw(10'h3B2, 5'h01, 5'h00, 1'b0), 32'hFFFF_FFFF, 32'h0);
      ck(destValue, 32'h1234_5440);
      ck(processIdOut, 8'h5A);
      pipe.op(iw(10'h3B2, 5'h01, 5'h01, 1'b0), 32'hFFFF_FFFF, 32'h0);
      ck(destValue, 32'hCAFE_0123);
      pipe.op(iw(10'h3B2, 5'h01, 5'h02, 1'b0), 32'h3F, 32'h0);
      ck(programException, 1'b0);
    end
  endtask
  // Base field zero, real base plus index, foreign id, then unrecorded form
  task t_search;
    begin
      processIdIn = 8'h5A;
      pipe.op(iw(10'h392, 5'h00, 5'h02, 1'b1), 32'hDEAD_BEEF, 32'h1234_5400);
      ck(destValue, 32'h3F);
      ck(conditionField, 4'h3);
      summaryOverflow = 1'b0;
      pipe.op(iw(10'h392, 5'h01, 5'h02, 1'b1), 32'h1234_0000, 32'h5400);
      ck(destValue, 32'h3F);
      ck(conditionField, 4'h2);
      processIdIn = 8'hA5;
      pipe.op(iw(10'h392, 5'h01, 5'h02, 1'b1), 32'h1234_0000, 32'h5400);
      ck(conditionField, 4'h0);
      processIdIn = 8'h5A;
      pipe.op(iw(10'h392, 5'h01, 5'h02, 1'b0), 32'h1234_0000, 32'h5400);
      ck(destValue, 32'h3F);
      ck(conditionField, 4'h0);
    end
  endtask
  // User attempt refused, then real invalidate
  task t_inval;
    begin
      userMode = 1'b1;
      pipe.op(iw(10'h172, 5'h00, 5'h00, 1'b0), 32'h0, 32'h0);
      ck(programException, 1'b1);
      userMode = 1'b0;
      pipe.op(iw(10'h172, 5'h00, 5'h00, 1'b0), 32'h0, 32'h0);
      pipe.op(iw(10'h3B2, 5'h01, 5'h00, 1'b0), 32'h3F, 32'h0);
      ck(destValue, 32'h1234_5400);
      summaryOverflow = 1'b1;
      pipe.op(iw(10'h392, 5'h00, 5'h02, 1'b1), 32'h0, 32'h1234_5400);
      ck(conditionField, 4'h1);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    t_read;
    t_search;
    t_inval;
    test_done;
  end
endmodule
